//--- logic/pin_sync.sv
// Two-flop synchroniser with edge detect taken after the second flop
module pin_sync
   import tcap_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Asynchronous pin and synchronised outputs
   input wire logic pin,
   output logic level,
   output logic rise,
   output logic fall
);
   logic meta_r; // First stage, read only by second
   logic sync_r; // Second stage
   logic prev_r; // Delayed copy for edges

   // Synchroniser chain
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         prev_r <= 1'b0;
      end else begin
         meta_r <= pin;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign level = sync_r;
   assign rise = sync_r & ~prev_r;
   assign fall = ~sync_r & prev_r;
endmodule

//--- logic/tcap_pkg.sv
// Package of constants and types for the 16-bit capture/compare pulse timer
// Overview of operation
// - Event mode counts selected pin edges
// - Period match raises irq, clears, continues
// - Soft capture copies counter, self-clears
// - Window mode counts pin AND prescaler
// - Edge select picks window gate polarity
// - Width mode starts on trigger edge
// - Opposite edge captures and raises irq
// - Single edge mode clears counter after capture
// - Double edge recaptures on next trigger
// - Capture edge mode bit is bit six
// - Pulse mode starts on edge or command
// - Second compare match toggles output flop
// - Period match toggles, clears, raises irq
// - Output flop resets to zero
// - Software may preset output flop
// - Second compare writes only in pulse mode
// - Control register is write only
package tcap_pkg;
   // Counter width
   localparam int CNT_W = 16;
   // Control register layout (write-only byte)
   localparam int CTL_W = 8;
   localparam int CTL_MODE_LSB = 0; // Two-bit mode field
   localparam int CTL_MODE_W = 2;
   localparam int CTL_FFPRE_BIT = 2; // Output flop preset value
   localparam int CTL_START_LSB = 4; // Start control field
   localparam int CTL_START_W = 2;
   localparam int CTL_CAPMODE_BIT = 6; // Capture edge mode / soft capture
   localparam logic [CTL_W-1:0] CTL_RST = 8'h00;
   localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
   // Internal prescaler ratio in mclk cycles
   localparam int PRESC_DIV = 16;
   localparam logic [3:0] PRESC_LAST = 4'hf;

   // Operating modes
   typedef enum logic [1:0] {
      MODE_EVENT,
      MODE_WINDOW,
      MODE_WIDTH,
      MODE_PULSE
   } tmode_e;

   // Start control values
   localparam logic [1:0] START_STOP = 2'h0;
   localparam logic [1:0] START_SOFT = 2'h1;
   localparam logic [1:0] START_TRIG = 2'h3;

   // Decoded control fields travel together
   typedef struct packed {
      tmode_e mode;
      logic [1:0] start;
      logic capmode;
      logic ff_preset;
   } tctl_s;

   // Decode a control byte into its fields
   function automatic tctl_s decode_ctl(input logic [CTL_W-1:0] v);
      tctl_s c;
      c.mode = tmode_e'(v[CTL_MODE_LSB +: CTL_MODE_W]);
      c.start = v[CTL_START_LSB +: CTL_START_W];
      c.capmode = v[CTL_CAPMODE_BIT];
      c.ff_preset = v[CTL_FFPRE_BIT];
      return c;
   endfunction
endpackage

//--- logic/tcap_timer.sv
// Top of the 16-bit counter with period match, capture and pulse output
module tcap_timer
   import tcap_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Control register write port
   input wire logic ctl_we,
   input wire logic [CTL_W-1:0] ctl_wdata,
   // Edge select configuration
   input wire logic input_edge_select,
   // Timer register writes
   input wire logic period_we,
   input wire logic [CNT_W-1:0] period_wdata,
   input wire logic second_we,
   input wire logic [CNT_W-1:0] second_wdata,
   // External pin
   input wire logic count_input_pin,
   // Status and outputs
   output logic [CNT_W-1:0] period_compare_reg,
   output logic [CNT_W-1:0] capture_second_compare_reg,
   output logic [CNT_W-1:0] count_value,
   output logic soft_capture_bit,
   output logic running,
   output logic pulse_output_flipflop,
   output logic timer_match_irq
);
   tctl_s ctl_r; // Decoded control register, never read back
   tctl_s wctl; // Fields of an incoming write
   logic [CNT_W-1:0] cnt_r;
   logic [3:0] presc_r; // Prescaler divider
   logic tick; // One-cycle internal clock enable
   logic pin_lvl, pin_rise, pin_fall;
   logic trig_edge, opp_edge;
   logic run_r;
   logic gate_prev_r; // Previous gated clock level in window mode
   logic gate_now;
   logic period_hit, second_hit;
   logic inc;

   // Pin passes two flops before use
   pin_sync pin_sync_i (
      .mclk(mclk),
      .rst_n(rst_n),
      .pin(count_input_pin),
      .level(pin_lvl),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   assign wctl = decode_ctl(ctl_wdata);
   // Trigger edge: rising when edge select low, else falling
   assign trig_edge = input_edge_select ? pin_fall : pin_rise;
   assign opp_edge = input_edge_select ? pin_rise : pin_fall;

   // Prescaler: internal clock enable every PRESC_DIV cycles
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         presc_r <= 4'h0;
      end else begin
         presc_r <= presc_r + 4'h1;
      end
   end
   assign tick = (presc_r == PRESC_LAST);

   // Control register, write only; a soft capture write also stores bit 6 in capmode
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ctl_r <= decode_ctl(CTL_RST);
      end else if (ctl_we) begin
         ctl_r <= wctl;
      end
   end

   // Soft capture flag sets on write, hardware clears after capture
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         soft_capture_bit <= 1'b0;
      end else if (ctl_we && wctl.capmode &&
                   (wctl.mode == MODE_EVENT || wctl.mode == MODE_WINDOW)) begin
         soft_capture_bit <= 1'b1;
      end else begin
         soft_capture_bit <= 1'b0;
      end
   end

   // Window gate: pin polarity by edge select, ANDed with internal clock
   assign gate_now = (pin_lvl ^ input_edge_select) & presc_r[3];
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         gate_prev_r <= 1'b0;
      end else begin
         gate_prev_r <= gate_now;
      end
   end

   // Run state: stop field halts, trigger or command starts
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         run_r <= 1'b0;
      end else if (ctl_we) begin
         // Event and window modes start at once; soft start in pulse mode
         run_r <= (wctl.start != START_STOP) &&
                  (wctl.mode inside {MODE_EVENT, MODE_WINDOW} ||
                   (wctl.mode == MODE_PULSE && wctl.start == START_SOFT));
      end else if (!run_r && ctl_r.start == START_TRIG && trig_edge &&
                   ctl_r.mode inside {MODE_WIDTH, MODE_PULSE}) begin
         run_r <= 1'b1;
      end else if (run_r && ctl_r.mode == MODE_WIDTH && opp_edge && !ctl_r.capmode) begin
         run_r <= 1'b0;
      end
   end
   assign running = run_r;

   // Increment condition per mode
   always_comb begin
      unique case (ctl_r.mode)
         MODE_EVENT: inc = run_r & trig_edge;
         MODE_WINDOW: inc = run_r & gate_now & ~gate_prev_r;
         MODE_WIDTH: inc = run_r & tick;
         MODE_PULSE: inc = run_r & tick;
      endcase
   end

   assign period_hit = run_r && (ctl_r.mode != MODE_WIDTH) && (cnt_r == period_compare_reg);
   // The count dwells on the compare value for a whole prescaler period, so the
   // match is taken only on the tick that leaves it; otherwise the flop would chatter
   assign second_hit = run_r && (ctl_r.mode == MODE_PULSE) && tick &&
                       (cnt_r == capture_second_compare_reg);

   // Up-counter
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cnt_r <= CNT_RST;
      end else if (ctl_we && wctl.start == START_STOP) begin
         cnt_r <= CNT_RST; // Stopping clears the count
      end else if (period_hit) begin
         cnt_r <= CNT_RST;
      end else if (ctl_r.mode == MODE_WIDTH && run_r && opp_edge && !ctl_r.capmode) begin
         cnt_r <= CNT_RST;
      end else if (inc) begin
         cnt_r <= cnt_r + 16'h0001;
      end
   end
   assign count_value = cnt_r;

   // Period register, cleared at reset so compares start from a known value
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         period_compare_reg <= CNT_RST;
      end else if (period_we) begin
         period_compare_reg <= period_wdata;
      end
   end

   // Capture / second compare register
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         capture_second_compare_reg <= CNT_RST;
      end else if (soft_capture_bit) begin
         capture_second_compare_reg <= cnt_r;
      end else if (ctl_r.mode == MODE_WIDTH && run_r && opp_edge) begin
         capture_second_compare_reg <= cnt_r;
      end else if (ctl_r.mode == MODE_WIDTH && run_r && trig_edge && ctl_r.capmode) begin
         capture_second_compare_reg <= cnt_r;
      end else if (second_we && ctl_r.mode == MODE_PULSE) begin
         capture_second_compare_reg <= second_wdata;
      end
   end

   // Output flop: preset by a stopping control write, toggles on either compare match alone in pulse mode, holds if both match in one cycle
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pulse_output_flipflop <= 1'b0;
      end else if (ctl_we && wctl.start == START_STOP) begin
         pulse_output_flipflop <= wctl.ff_preset;
      end else if (second_hit ^ period_hit && ctl_r.mode == MODE_PULSE) begin
         pulse_output_flipflop <= ~pulse_output_flipflop;
      end
   end

   // Interrupt request pulse, registered
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         timer_match_irq <= 1'b0;
      end else begin
         timer_match_irq <= period_hit ||
                            (ctl_r.mode == MODE_WIDTH && run_r && opp_edge);
      end
   end
endmodule

//--- testbench/pin_src.sv
// Pulse source on the count pin and load on the pulse output
module pin_src (
   // Clock and pulse load
   input wire logic mclk,
   input wire logic pulse_output_flipflop,
   // Driven pin
   output logic count_input_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   int toggles = 0; // Edges seen by the load
   logic last_r = 1'b0;
   initial count_input_pin = 1'b0;
   // Load wired straight to the flop: sampled on each falling clock edge, every change counted
   always @(negedge mclk) begin
      if (pulse_output_flipflop !== last_r) toggles++;
      last_r <= pulse_output_flipflop;
   end
   // Callers hold each level 16 cycles or more, slow beside the clock
   task automatic lvl(input logic v, input int n);
      @(posedge mclk) count_input_pin <= v;
      repeat (n - 1) @(posedge mclk);
      #1;
   endtask
endmodule

//--- testbench/tcap_chk.sv
// Port checker for the capture/compare pulse timer
module tcap_chk
   import tcap_pkg::*;
(
   // Clock, reset and writes
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ctl_we,
   input wire logic [CTL_W-1:0] ctl_wdata,
   input wire logic second_we,
   input wire logic [CNT_W-1:0] second_wdata,
   // Timer outputs
   input wire logic [CNT_W-1:0] period_compare_reg,
   input wire logic [CNT_W-1:0] capture_second_compare_reg,
   input wire logic [CNT_W-1:0] count_value,
   input wire logic soft_capture_bit,
   input wire logic running,
   input wire logic pulse_output_flipflop,
   input wire logic timer_match_irq
);
   tmode_e mode_r; // Mode in force
   logic pmatch; // Counter sits on second compare
   // Follow the mode so each rule is judged only where it applies
   always_ff @(posedge mclk) begin
      if (!rst_n) mode_r <= MODE_EVENT;
      else if (ctl_we) mode_r <= tmode_e'(ctl_wdata[1:0]);
   end
   assign pmatch = running && mode_r == MODE_PULSE && count_value != 16'h0000
      && count_value == capture_second_compare_reg;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence soft_req;
      ctl_we && ctl_wdata[6] && !ctl_wdata[1] && running;
   endsequence
   sequence bit_pulse;
      ##1 soft_capture_bit ##1 !soft_capture_bit;
   endsequence
   AST_IRQ_ONE: assert property (timer_match_irq |=> !timer_match_irq)
      else $error("irq longer than one cycle");
   AST_SOFT_BIT: assert property (soft_req |-> bit_pulse)
      else $error("soft capture bit not a one-cycle pulse");
   AST_WRAP_IRQ: assert property (running && $past(running) && mode_r != MODE_WIDTH
      && period_compare_reg != 16'h0000 && count_value == 16'h0000
      && $past(count_value) == period_compare_reg |-> timer_match_irq)
      else $error("period wrap without irq");
   AST_IRQ_ZERO: assert property (timer_match_irq && mode_r != MODE_WIDTH
      |-> count_value == 16'h0000)
      else $error("irq without cleared counter");
   AST_FLOP_RST: assert property ($rose(rst_n) |-> !pulse_output_flipflop)
      else $error("output flop not zero after reset");
   AST_SEC_IGNORE: assert property (second_we && !running && mode_r != MODE_PULSE
      |=> $stable(capture_second_compare_reg))
      else $error("second compare written outside pulse mode");
   AST_SEC_LOAD: assert property (second_we && mode_r == MODE_PULSE
      |=> capture_second_compare_reg == $past(second_wdata))
      else $error("second compare not loaded");
   AST_TOGGLE: assert property ($rose(pmatch) |-> ##[0:17] $changed(pulse_output_flipflop))
      else $error("no toggle on second compare match");
endmodule

//--- testbench/tcap_timer_bench.sv
// Self-checking bench for the capture/compare pulse timer
module tcap_timer_bench
   import tcap_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 0, rst_n = 0, ctl_we = 0, period_we = 0, second_we = 0;
   logic input_edge_select = 0, count_input_pin;
   logic [CTL_W-1:0] ctl_wdata = 0;
   logic [CNT_W-1:0] period_wdata = 0, second_wdata = 0;
   logic [CNT_W-1:0] period_compare_reg, capture_second_compare_reg, count_value;
   logic soft_capture_bit, running, pulse_output_flipflop, timer_match_irq;
   int miscompares = 0, cmp_count = 0, irqs = 0, c0, t;
   logic [CNT_W-1:0] v;
   tcap_timer tcap_timer_i (.mclk, .rst_n, .ctl_we, .ctl_wdata, .input_edge_select,
      .period_we, .period_wdata, .second_we, .second_wdata, .count_input_pin,
      .period_compare_reg, .capture_second_compare_reg, .count_value,
      .soft_capture_bit, .running, .pulse_output_flipflop, .timer_match_irq);
   pin_src pin_src_i (.mclk, .pulse_output_flipflop, .count_input_pin);
   initial forever #50 mclk = ~mclk;
   // Irq sampled mid-cycle, where it is settled
   always @(negedge mclk) if (timer_match_irq === 1'b1) irqs++;
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // Write: k 0 control, 1 period, 2 second compare
   task automatic wr(input int k, input logic [15:0] d);
      @(posedge mclk);
      ctl_we <= (k == 0);
      period_we <= (k == 1);
      second_we <= (k == 2);
      ctl_wdata <= d[7:0];
      period_wdata <= d;
      second_wdata <= d;
      @(posedge mclk);
      ctl_we <= 1'b0;
      period_we <= 1'b0;
      second_we <= 1'b0;
      #1;
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] lo, input logic [15:0] hi);
      cmp_count++;
      if ((g >= lo && g <= hi) !== 1'b1) begin
         $display("ERROR %0t got %h want %h..%h", $time, g, lo, hi);
         miscompares++;
      end
   endtask
   task automatic finish_test;
      $display("Counts: %0d mismatches, %0d compares", miscompares, cmp_count);
      if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Bounded wait for the next irq
   task automatic wirq(input int n);
      for (int i = 0; i < 400; i++) begin
         cyc(1);
         if (irqs > n) return;
      end
      $display("ERROR %0t irq timeout", $time);
      miscompares++;
      finish_test();
   endtask
   initial begin
      cyc(11);
      @(posedge mclk) rst_n <= 1'b1;
      cyc(1);
      chk(16'(pulse_output_flipflop), 0, 0);
      // Event counting on rising edges, wrap at period 3
      wr(0, 16'h0000);
      wr(1, 16'h0003);
      chk(period_compare_reg, 3, 3);
      wr(0, 16'h0010);
      c0 = irqs;
      repeat (2) begin
         pin_src_i.lvl(1, 20);
         pin_src_i.lvl(0, 20);
      end
      chk(count_value, 2, 2);
      wr(0, 16'h0050);
      cyc(3);
      chk(capture_second_compare_reg, 2, 2);
      pin_src_i.lvl(1, 20);
      pin_src_i.lvl(0, 20);
      chk(count_value, 0, 0);
      chk(16'(irqs - c0), 1, 1);
      pin_src_i.lvl(1, 20);
      pin_src_i.lvl(0, 20);
      chk(count_value, 1, 1);
      $display("Test event done");
      // Falling edge select; refused second compare write
      wr(0, 16'h0000);
      @(posedge mclk) input_edge_select <= 1'b1;
      wr(2, 16'h0005);
      chk(capture_second_compare_reg, 2, 2);
      wr(0, 16'h0010);
      pin_src_i.lvl(1, 20);
      chk(count_value, 0, 0);
      pin_src_i.lvl(0, 20);
      chk(count_value, 1, 1);
      $display("Test edge done");
      // Window gate, high then low active
      for (int pol = 0; pol < 2; pol++) begin
         wr(0, 16'h0001);
         @(posedge mclk) input_edge_select <= pol[0];
         wr(1, 16'hffff);
         wr(0, 16'h0011);
         pin_src_i.lvl(!pol[0], 160);
         pin_src_i.lvl(pol[0], 20);
         v = count_value;
         chk(v, 9, 11);
         pin_src_i.lvl(pol[0], 140);
         chk(count_value, v, v);
         pin_src_i.lvl(0, 20);
      end
      $display("Test window done");
      // Width, single then double edge capture
      wr(0, 16'h0002);
      @(posedge mclk) input_edge_select <= 1'b0;
      wr(0, 16'h0032);
      c0 = irqs;
      pin_src_i.lvl(1, 160);
      pin_src_i.lvl(0, 20);
      chk(capture_second_compare_reg, 9, 11);
      chk(count_value, 0, 0);
      chk(16'(irqs - c0), 1, 1);
      wr(0, 16'h0042);
      wr(0, 16'h0072);
      pin_src_i.lvl(1, 160);
      pin_src_i.lvl(0, 160);
      chk(capture_second_compare_reg, 9, 11);
      pin_src_i.lvl(1, 20);
      chk(capture_second_compare_reg, 19, 21);
      $display("Test width done");
      // Pulse output: preset, compares, soft start
      wr(0, 16'h0007);
      chk(16'(pulse_output_flipflop), 1, 1);
      wr(0, 16'h0003);
      chk(16'(pulse_output_flipflop), 0, 0);
      wr(1, 16'h0008);
      wr(2, 16'h0003);
      chk(capture_second_compare_reg, 3, 3);
      wr(0, 16'h0013);
      wirq(irqs);
      chk(count_value, 0, 0);
      cyc(3);
      t = pin_src_i.toggles;
      wirq(irqs);
      cyc(3);
      chk(16'(pin_src_i.toggles - t), 2, 2);
      // Trigger start waits for the pin edge
      wr(0, 16'h0003);
      pin_src_i.lvl(0, 20);
      wr(0, 16'h0033);
      cyc(40);
      chk(16'(running), 0, 0);
      pin_src_i.lvl(1, 20);
      chk(16'(running), 1, 1);
      $display("Test pulse done");
      finish_test();
   end
endmodule
bind tcap_timer tcap_chk tcap_chk_i (.mclk, .rst_n, .ctl_we, .ctl_wdata, .second_we,
   .second_wdata, .period_compare_reg, .capture_second_compare_reg, .count_value,
   .soft_capture_bit, .running, .pulse_output_flipflop, .timer_match_irq);
